//--- tcps_ctrl.sv
// Timer clock, power management and system control register bank
// Notes on behaviour
// - Each timer divider field divides by 1, 2, 4 or 8; resets to 0.
// - Source bit 1 picks system clock, 0 reference clock; gate bit enables; timer C gate and source bits are not writable, so it never runs.
// - Bits 15 and 14 keep ECC RAM and cache powered in deep sleep.
// - Clockless sleep stops the low-power clock until a wakeup event.
// - Five keep bits, one per system RAM macro, for deep sleep.
// - Two-bit field sets the AHB clock divider during OTP mirroring.
// - Reset-after-wakeup bit issues a hardware reset when waking.
// - BLE power-down bit, reset 1; BLE access with clock off faults.
// - Bits 1 and 0 power down radio and peripherals; both reset to 1.
// - Writing 1 to bit 15 of system control triggers a software reset.
// - Vector redirect maps CPU addresses 0 to 0xFF into system RAM.
// - Mirror bit copies OTP into system RAM after system domain wakes.
// - Development phase bit suppresses the OTP copy on wakeup.
// - Bit 12 starts quad serial flash port initialisation after wakeup.
// - Cache mapping bit 0 bypasses cache and exposes its RAM.
// - Power state machine proceeds after 2 ms unless timeout is disabled.
// - Debugger bit clear lets debug pins serve as general-purpose I/O.
// - Bit 6 asserts a reset request to the OTP controller.
// - Pad latch bit 0 holds pad controls; 1 is transparent; resets to 1.
// - Two-bit field orders the first three data RAMs in the map.
`timescale 1ns/10ps
module tcps_ctrl
   import tcps_pkg::*;
#(
   parameter int PSM_TIMEOUT = PSM_TIMEOUT_CYCLES
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic divided_reference_clock,
   output logic [2:0] timer_tick,
   input wire logic deep_sleep_active,
   input wire logic wakeup_event,
   input wire logic wakeup_done,
   input wire logic otp_copy_active,
   input wire logic ble_core_clock_gate,
   input wire logic ble_reg_access,
   input wire logic [31:0] cpu_addr,
   input wire logic blocks_start_req,
   input wire logic blocks_started,
   output logic ecc_memory_keep,
   output logic cache_block_keep,
   output logic [4:0] data_memory_keep_mask,
   output logic low_power_clock_run,
   output logic [1:0] ahb_clock_divider,
   output logic wakeup_hw_reset,
   output logic ble_core_power_down,
   output logic ble_hard_fault,
   output logic radio_power_down,
   output logic peripheral_domain_power_down,
   output logic software_reset_trigger,
   output logic [31:0] cpu_addr_mapped,
   output logic otp_copy_start,
   output logic otp_copy_emulate,
   output logic qspi_init_start,
   output logic cache_enable,
   output logic cache_ram_visible,
   output logic psm_proceed,
   output logic debugger_enable,
   output logic swd_pins_gpio,
   output logic otp_controller_reset_request,
   output logic pad_latch_transparent,
   output logic [1:0] ram_slot0_select,
   output logic [1:0] ram_slot1_select,
   output logic [1:0] ram_slot2_select
);

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   function automatic tcps_sel_t decode(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-3:0] idx;
      idx = addr[ADDR_W-1:2];
      if (idx == IDX_TIMER_CLOCK_CONTROL[ADDR_W-3:0]) decode = TCPS_SEL_TMR;
      else if (idx == IDX_POWER_UNIT_CONTROL[ADDR_W-3:0]) decode = TCPS_SEL_PMU;
      else if (idx == IDX_SYSTEM_CONTROL[ADDR_W-3:0]) decode = TCPS_SEL_SYS;
      else if (idx == IDX_BANK_STATUS[ADDR_W-3:0]) decode = TCPS_SEL_STAT;
      else decode = TCPS_SEL_NONE;
   endfunction : decode

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                         input logic [1:0] strb, input logic [15:0] mask);
      logic [15:0] lane;
      lane = {{8{strb[1]}}, {8{strb[0]}}} & mask;
      merge = (old & ~lane) | (wd & lane);
   endfunction : merge

   // Data RAM number (0 = first) placed in a slot of the map
   function automatic logic [1:0] ram_order(input logic [1:0] sel, input logic [1:0] slot);
      case ({sel, slot})
         4'h0: ram_order = 2'h0;
         4'h1: ram_order = 2'h1;
         4'h2: ram_order = 2'h2;
         4'h4: ram_order = 2'h1;
         4'h5: ram_order = 2'h0;
         4'h6: ram_order = 2'h2;
         4'h8: ram_order = 2'h2;
         4'h9: ram_order = 2'h0;
         4'ha: ram_order = 2'h1;
         4'hc: ram_order = 2'h2;
         4'hd: ram_order = 2'h1;
         default: ram_order = 2'h0;
      endcase
   endfunction : ram_order

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path

   logic [ADDR_W-1:0] awaddr_q;
   logic [15:0] wdata_q;
   logic [1:0] wstrb_q;
   logic aw_hold_q;
   logic w_hold_q;
   logic wr_fire;
   tcps_sel_t wr_sel;
   logic [15:0] tmr_q;
   logic [15:0] pmu_q;
   logic [15:0] sys_q;

   assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
   assign wr_sel = decode(awaddr_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         aw_hold_q <= 1'b0;
         awaddr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_hold_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else begin
         if (wr_fire) aw_hold_q <= 1'b0;
         if (!aw_hold_q && !s_axi_bvalid) s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b0;
         w_hold_q <= 1'b0;
         wdata_q <= 16'h0000;
         wstrb_q <= 2'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_hold_q <= 1'b1;
         wdata_q <= s_axi_wdata[15:0];
         wstrb_q <= s_axi_wstrb[1:0];
      end else begin
         if (wr_fire) w_hold_q <= 1'b0;
         if (!w_hold_q && !s_axi_bvalid) s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wr_sel == TCPS_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control registers; status register ignores writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tmr_q <= RST_TIMER_CLOCK_CONTROL;
         pmu_q <= RST_POWER_UNIT_CONTROL;
         sys_q <= RST_SYSTEM_CONTROL;
      end else if (wr_fire) begin
         if (wr_sel == TCPS_SEL_TMR) tmr_q <= merge(tmr_q, wdata_q, wstrb_q,
                                                    MASK_TIMER_CLOCK_CONTROL);
         if (wr_sel == TCPS_SEL_PMU) pmu_q <= merge(pmu_q, wdata_q, wstrb_q,
                                                    MASK_POWER_UNIT_CONTROL);
         if (wr_sel == TCPS_SEL_SYS) sys_q <= merge(sys_q, wdata_q, wstrb_q,
                                                    MASK_SYSTEM_CONTROL);
      end
   end

   // Self-clearing pulse, never stored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         software_reset_trigger <= 1'b0;
      end else begin
         software_reset_trigger <= wr_fire && (wr_sel == TCPS_SEL_SYS) && wstrb_q[1]
                                   && wdata_q[SYS_SOFT_RST_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path

   tcps_psm_t psm_q;
   logic lp_stopped_q;
   logic psm_timed_out_q;
   logic [15:0] status_word;

   assign status_word = {13'h0000, psm_timed_out_q, psm_q == TCPS_PSM_WAIT, lp_stopped_q};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         case (decode(s_axi_araddr))
            TCPS_SEL_TMR: s_axi_rdata <= {16'h0000, tmr_q};
            TCPS_SEL_PMU: s_axi_rdata <= {16'h0000, pmu_q};
            TCPS_SEL_SYS: s_axi_rdata <= {16'h0000, sys_q};
            TCPS_SEL_STAT: s_axi_rdata <= {16'h0000, status_word};
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else begin
         if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
         if (!s_axi_rvalid) s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timer clock paths

   logic [2:0] ref_sync_q;
   logic ref_tick;

   always_ff @(posedge aclk) begin
      if (!aresetn) ref_sync_q <= 3'h0;
      else ref_sync_q <= {ref_sync_q[1:0], divided_reference_clock};
   end

   assign ref_tick = ref_sync_q[1] && !ref_sync_q[2];

   generate
      for (genvar i = 0; i < 3; i++) begin : g_timer
         localparam int B = (i < 2) ? i * TMR_FIELD_STRIDE : TMR_C_DIV_LSB;
         localparam int G = (i < 2) ? B + TMR_GATE_BIT : TMR_C_GATE_BIT;
         localparam int S = (i < 2) ? B + TMR_SEL_BIT : TMR_C_SEL_BIT;
         tcps_timer_clk u_timer_clk (
            .aclk(aclk),
            .aresetn(aresetn),
            .ref_tick(ref_tick),
            .gate_en(tmr_q[G]),
            .source_sel(tmr_q[S]),
            .divider(tmr_q[B+1:B]),
            .timer_tick(timer_tick[i])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Power management

   logic [1:0] wake_sync_q;
   logic lp_stopped_d;

   always_ff @(posedge aclk) begin
      if (!aresetn) wake_sync_q <= 2'h0;
      else wake_sync_q <= {wake_sync_q[0], wakeup_event};
   end

   // Undebounced wakeup releases the stopped low-power clock
   always_comb begin
      lp_stopped_d = lp_stopped_q;
      if (wake_sync_q[1] || !deep_sleep_active) lp_stopped_d = 1'b0;
      else if (pmu_q[PMU_CLKLESS_BIT]) lp_stopped_d = 1'b1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lp_stopped_q <= 1'b0;
         low_power_clock_run <= 1'b1;
      end else begin
         lp_stopped_q <= lp_stopped_d;
         low_power_clock_run <= !lp_stopped_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ecc_memory_keep <= 1'b0;
         cache_block_keep <= 1'b0;
         data_memory_keep_mask <= 5'h00;
         ahb_clock_divider <= 2'h0;
         ble_core_power_down <= 1'b1;
         radio_power_down <= 1'b1;
         peripheral_domain_power_down <= 1'b1;
      end else begin
         ecc_memory_keep <= pmu_q[PMU_ECC_KEEP_BIT];
         cache_block_keep <= pmu_q[PMU_CACHE_KEEP_BIT];
         data_memory_keep_mask <= pmu_q[PMU_RAM_KEEP_LSB+4:PMU_RAM_KEEP_LSB];
         ahb_clock_divider <= otp_copy_active ?
                              pmu_q[PMU_OTP_DIV_LSB+1:PMU_OTP_DIV_LSB] : 2'h0;
         ble_core_power_down <= pmu_q[PMU_BLE_PD_BIT];
         radio_power_down <= pmu_q[PMU_RADIO_PD_BIT];
         peripheral_domain_power_down <= pmu_q[PMU_PERIPH_PD_BIT];
      end
   end

   // Wakeup-triggered one-cycle actions and the BLE access fault
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wakeup_hw_reset <= 1'b0;
         otp_copy_start <= 1'b0;
         otp_copy_emulate <= 1'b0;
         qspi_init_start <= 1'b0;
         ble_hard_fault <= 1'b0;
      end else begin
         wakeup_hw_reset <= wakeup_done && pmu_q[PMU_RESET_WAKE_BIT];
         otp_copy_start <= wakeup_done && sys_q[SYS_OTP_COPY_BIT]
                           && !sys_q[SYS_DEV_STAGE_BIT];
         otp_copy_emulate <= wakeup_done && sys_q[SYS_OTP_COPY_BIT]
                             && sys_q[SYS_DEV_STAGE_BIT];
         qspi_init_start <= wakeup_done && sys_q[SYS_QSPI_INIT_BIT];
         ble_hard_fault <= ble_reg_access && (pmu_q[PMU_BLE_PD_BIT]
                                              || !ble_core_clock_gate);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // System control

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_addr_mapped <= 32'h00000000;
      end else if (sys_q[SYS_REDIRECT_BIT] && (cpu_addr <= VECTOR_REDIRECT_TOP)) begin
         cpu_addr_mapped <= VECTOR_REDIRECT_BASE | cpu_addr;
      end else begin
         cpu_addr_mapped <= cpu_addr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cache_enable <= 1'b0;
         cache_ram_visible <= 1'b1;
         debugger_enable <= 1'b0;
         swd_pins_gpio <= 1'b1;
         otp_controller_reset_request <= 1'b0;
         pad_latch_transparent <= 1'b1;
         ram_slot0_select <= 2'h0;
         ram_slot1_select <= 2'h1;
         ram_slot2_select <= 2'h2;
      end else begin
         cache_enable <= sys_q[SYS_CACHE_MAP_BIT];
         cache_ram_visible <= !sys_q[SYS_CACHE_MAP_BIT];
         debugger_enable <= sys_q[SYS_DEBUGGER_BIT];
         swd_pins_gpio <= !sys_q[SYS_DEBUGGER_BIT];
         otp_controller_reset_request <= sys_q[SYS_OTPC_RESET_BIT];
         pad_latch_transparent <= sys_q[SYS_PAD_LATCH_BIT];
         ram_slot0_select <= ram_order(sys_q[SYS_RAM_ORDER_LSB+1:SYS_RAM_ORDER_LSB],
                                       2'h0);
         ram_slot1_select <= ram_order(sys_q[SYS_RAM_ORDER_LSB+1:SYS_RAM_ORDER_LSB],
                                       2'h1);
         ram_slot2_select <= ram_order(sys_q[SYS_RAM_ORDER_LSB+1:SYS_RAM_ORDER_LSB],
                                       2'h2);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power state machine start-up timeout

   logic [PSM_CNT_W-1:0] psm_cnt_q;
   logic psm_expired;

   assign psm_expired = !sys_q[SYS_TIMEOUT_DIS_BIT]
                        && (psm_cnt_q >= PSM_CNT_W'(PSM_TIMEOUT - 1));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         psm_q <= TCPS_PSM_IDLE;
         psm_cnt_q <= '0;
         psm_proceed <= 1'b0;
         psm_timed_out_q <= 1'b0;
      end else begin
         psm_proceed <= 1'b0;
         case (psm_q)
            TCPS_PSM_IDLE: begin
               psm_cnt_q <= '0;
               if (blocks_start_req) psm_q <= TCPS_PSM_WAIT;
            end
            TCPS_PSM_WAIT: begin
               if (blocks_started || psm_expired) begin
                  psm_q <= TCPS_PSM_DONE;
                  psm_proceed <= 1'b1;
                  psm_timed_out_q <= !blocks_started;
               end else if (!(&psm_cnt_q)) begin
                  psm_cnt_q <= psm_cnt_q + PSM_CNT_W'(1);
               end
            end
            TCPS_PSM_DONE: begin
               psm_q <= TCPS_PSM_IDLE;
            end
            default: psm_q <= TCPS_PSM_IDLE;
         endcase
      end
   end

endmodule : tcps_ctrl

//--- tcps_ctrl_bench.sv
// Self-checking bench for the control bank
`timescale 1ns/10ps
`define CK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
   $display("ERROR at %0t: %h vs %h", $time, (a), (b)); end end
module tcps_ctrl_bench;
   import tcps_pkg::*;
   typedef struct {logic [11:0] a; logic [15:0] d; logic [15:0] e;} tcps_row_t;
   tcps_row_t rows [6] = '{'{12'h030, 16'h0, 16'h0}, '{12'h040, 16'h0, 16'h8},
      '{12'h048, 16'h0, 16'h0}, '{12'h030, 16'hffff, 16'h3ff},
      '{12'h040, 16'hffff, 16'hffef}, '{12'h048, 16'h7fff, 16'h7ef8}};
   logic [5:0] ord [4] = '{6'h06, 6'h12, 6'h21, 6'h24};
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, divided_reference_clock = 0;
   logic [ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0, timer_tick;
   logic [DATA_W-1:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h3;
   logic [1:0] s_axi_bresp, s_axi_rresp, ahb_clock_divider, rs;
   logic [1:0] ram_slot0_select, ram_slot1_select, ram_slot2_select;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic deep_sleep_active = 0, wakeup_event = 0, wakeup_done = 0, otp_copy_active = 0;
   logic ble_core_clock_gate = 0, ble_reg_access = 0, blocks_start_req = 0, blocks_started = 0;
   logic [31:0] cpu_addr = 0, cpu_addr_mapped;
   logic [4:0] data_memory_keep_mask;
   logic ecc_memory_keep, cache_block_keep, low_power_clock_run, wakeup_hw_reset;
   logic ble_core_power_down, ble_hard_fault, radio_power_down, peripheral_domain_power_down;
   logic software_reset_trigger, otp_copy_start, otp_copy_emulate, qspi_init_start;
   logic cache_enable, cache_ram_visible, psm_proceed, debugger_enable, swd_pins_gpio;
   logic otp_controller_reset_request, pad_latch_transparent;
   logic [15:0] rdv;
   int num_errors = 0, checks = 0, cyc = 0, swr = 0, tk0, tk1;
   tcps_ctrl #(.PSM_TIMEOUT(16)) u_tcps_ctrl (.*);
   initial forever #50 aclk = ~aclk;
   initial forever #400 divided_reference_clock = ~divided_reference_clock;
   always @(posedge aclk) begin
      cyc++;
      swr += software_reset_trigger;
      if (cyc == 6000) begin
         num_errors++;
         report_and_stop;
      end
   end
   ////////////////////////////////////////
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      fork
         begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
         begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
      join
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic chk(input logic [11:0] a, input logic [15:0] e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      rdv = s_axi_rdata[15:0];
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      `CK(rdv, e)
   endtask : chk
   task automatic tcount(input int e);
      repeat (4) @(posedge aclk);
      tk0 = 0;
      tk1 = 0;
      repeat (64) begin
         @(posedge aclk);
         tk0 += timer_tick[0];
         tk1 += timer_tick[1];
      end
      `CK(tk0, e)
      `CK(tk1, e)
   endtask : tcount
   task automatic ble(input logic e);
      ble_reg_access <= 1'b1;
      @(posedge aclk);
      ble_reg_access <= 1'b0;
      #1 `CK(ble_hard_fault, e)
   endtask : ble
   task automatic wake(input logic [3:0] e);
      wakeup_done <= 1'b1;
      @(posedge aclk);
      wakeup_done <= 1'b0;
      #1 `CK({wakeup_hw_reset, otp_copy_start, otp_copy_emulate, qspi_init_start}, e)
   endtask : wake
   task automatic psm_run(input logic start);
      if (start) begin
         blocks_start_req <= 1'b1;
         @(posedge aclk);
         blocks_start_req <= 1'b0;
      end
      tk0 = 0;
      while (psm_proceed !== 1'b1 && tk0 < 40) begin
         @(posedge aclk);
         #1 tk0++;
      end
   endtask : psm_run
   task automatic report_and_stop;
      $display("Errors %0d, checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(12'h030, 16'h0000);
      chk(12'h040, 16'h000f);
      chk(12'h048, 16'h0020);
      `CK({ble_core_power_down, radio_power_down, peripheral_domain_power_down}, 3'h7)
      for (int i = 0; i < 6; i++) begin
         wr(rows[i].a, rows[i].d);
         chk(rows[i].a, rows[i].e);
      end
      #1 `CK({ecc_memory_keep, cache_block_keep, data_memory_keep_mask}, 7'h7f)
      `CK({cache_enable, debugger_enable, otp_controller_reset_request}, 3'h7)
      wr(12'h100, 16'hffff);
      `CK(rs, RESP_SLVERR)
      chk(12'h100, 16'h0000);
      `CK(rs, RESP_SLVERR)
      for (int d = 0; d < 4; d++) begin
         wr(12'h030, {8'h0, 2'h3, 2'(d), 2'h3, 2'(d)});
         tcount(64 >> d);
      end
      wr(12'h030, 16'h0044);
      tcount(8);
      wr(12'h030, 16'h0000);
      tcount(0);
      for (int c = 0; c < 4; c++) begin
         wr(12'h048, {11'h0, 2'(c), 3'h0});
         #1 `CK({ram_slot0_select, ram_slot1_select, ram_slot2_select}, ord[c])
      end
      `CK(pad_latch_transparent, 1'b0)
      ble_core_clock_gate <= 1'b1;
      ble(1'b1);
      wr(12'h040, 16'h0020);
      ble(1'b0);
      ble_core_clock_gate <= 1'b0;
      ble(1'b1);
      wr(12'h048, 16'h3020);
      wake(4'hd);
      wr(12'h048, 16'h3820);
      wake(4'hb);
      wr(12'h048, 16'h8000);
      chk(12'h048, 16'h0000);
      wr(12'h048, 16'h4000);
      `CK(swr, 1)
      cpu_addr <= 32'hff;
      repeat (2) @(posedge aclk);
      #1 `CK(cpu_addr_mapped, 32'h07fc00ff)
      cpu_addr <= 32'h100;
      repeat (2) @(posedge aclk);
      #1 `CK(cpu_addr_mapped, 32'h00000100)
      psm_run(1'b1);
      `CK(tk0 inside {16, 17}, 1'b1)
      chk(12'h060, 16'h0004);
      wr(12'h048, 16'h0200);
      psm_run(1'b1);
      `CK(tk0, 40)
      blocks_started <= 1'b1;
      psm_run(1'b0);
      `CK(tk0 < 4, 1'b1)
      wr(12'h040, 16'h2080);
      deep_sleep_active <= 1'b1;
      otp_copy_active <= 1'b1;
      repeat (3) @(posedge aclk);
      #1 `CK(low_power_clock_run, 1'b0)
      `CK(ahb_clock_divider, 2'h2)
      wakeup_event <= 1'b1;
      repeat (6) @(posedge aclk);
      #1 `CK(low_power_clock_run, 1'b1)
      report_and_stop;
   end
endmodule : tcps_ctrl_bench

//--- tcps_ctrl_props.sv
// Concurrent checks on the control bank outputs
`timescale 1ns/10ps
module tcps_ctrl_props #(parameter int PSM_TIMEOUT = 16) (
   input logic aclk,
   input logic aresetn,
   input logic ble_reg_access,
   input logic ble_core_clock_gate,
   input logic ble_hard_fault,
   input logic software_reset_trigger,
   input logic [31:0] cpu_addr,
   input logic [31:0] cpu_addr_mapped,
   input logic cache_enable,
   input logic cache_ram_visible,
   input logic debugger_enable,
   input logic swd_pins_gpio,
   input logic [2:0] timer_tick
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ble_fault_a:
   assert property (ble_reg_access && !ble_core_clock_gate |=> ble_hard_fault)
      else $error("fault missing");
   fault_cause_a:
   assert property (ble_hard_fault |-> $past(ble_reg_access))
      else $error("fault without access");
   sw_pulse_a:
   assert property (software_reset_trigger |=> !software_reset_trigger)
      else $error("reset pulse too long");
   addr_pass_a:
   assert property (cpu_addr > 32'hff |=> cpu_addr_mapped == $past(cpu_addr))
      else $error("address altered");
   addr_low_a:
   assert property (cpu_addr <= 32'hff |=> cpu_addr_mapped[7:0] == $past(cpu_addr[7:0]))
      else $error("low address bits lost");
   cache_map_a:
   assert property (cache_enable != cache_ram_visible)
      else $error("cache map clash");
   debug_gpio_a:
   assert property (debugger_enable != swd_pins_gpio)
      else $error("debug pin clash");
   tmr_c_idle_a:
   assert property (!timer_tick[2])
      else $error("timer c ticks");
endmodule : tcps_ctrl_props
bind tcps_ctrl tcps_ctrl_props #(.PSM_TIMEOUT(PSM_TIMEOUT)) u_tcps_ctrl_props (.*);

//--- tcps_pkg.sv
// Package of constants and types for the timer, clock and power control bank
package tcps_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Register indices; byte address is four times the index (low two address bits not decoded)
   localparam logic [31:0] IDX_TIMER_CLOCK_CONTROL = 32'h5000000c;
   localparam logic [31:0] IDX_POWER_UNIT_CONTROL = 32'h50000010;
   localparam logic [31:0] IDX_SYSTEM_CONTROL = 32'h50000012;
   localparam logic [31:0] IDX_BANK_STATUS = 32'h50000018;

   typedef enum logic [2:0] {
      TCPS_SEL_NONE = 3'h0,
      TCPS_SEL_TMR = 3'h1,
      TCPS_SEL_PMU = 3'h2,
      TCPS_SEL_SYS = 3'h3,
      TCPS_SEL_STAT = 3'h4
   } tcps_sel_t;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and writable masks
   localparam logic [15:0] RST_TIMER_CLOCK_CONTROL = 16'h0000;
   localparam logic [15:0] RST_POWER_UNIT_CONTROL = 16'h000f;
   localparam logic [15:0] RST_SYSTEM_CONTROL = 16'h0020;
   localparam logic [15:0] MASK_TIMER_CLOCK_CONTROL = 16'h03ff;
   localparam logic [15:0] MASK_POWER_UNIT_CONTROL = 16'hffe7;
   localparam logic [15:0] MASK_SYSTEM_CONTROL = 16'h7ef8;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int TMR_FIELD_STRIDE = 4;
   localparam int TMR_DIV_LSB = 0;
   localparam int TMR_GATE_BIT = 2;
   localparam int TMR_SEL_BIT = 3;
   localparam int TMR_C_DIV_LSB = 8;
   localparam int TMR_C_GATE_BIT = 10;
   localparam int TMR_C_SEL_BIT = 11;

   localparam int PMU_ECC_KEEP_BIT = 15;
   localparam int PMU_CACHE_KEEP_BIT = 14;
   localparam int PMU_CLKLESS_BIT = 13;
   localparam int PMU_RAM_KEEP_LSB = 8;
   localparam int PMU_OTP_DIV_LSB = 6;
   localparam int PMU_RESET_WAKE_BIT = 5;
   localparam int PMU_BLE_PD_BIT = 2;
   localparam int PMU_RADIO_PD_BIT = 1;
   localparam int PMU_PERIPH_PD_BIT = 0;

   localparam int SYS_SOFT_RST_BIT = 15;
   localparam int SYS_REDIRECT_BIT = 14;
   localparam int SYS_OTP_COPY_BIT = 13;
   localparam int SYS_QSPI_INIT_BIT = 12;
   localparam int SYS_DEV_STAGE_BIT = 11;
   localparam int SYS_CACHE_MAP_BIT = 10;
   localparam int SYS_TIMEOUT_DIS_BIT = 9;
   localparam int SYS_DEBUGGER_BIT = 7;
   localparam int SYS_OTPC_RESET_BIT = 6;
   localparam int SYS_PAD_LATCH_BIT = 5;
   localparam int SYS_RAM_ORDER_LSB = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Memory map and timing
   localparam logic [31:0] VECTOR_REDIRECT_BASE = 32'h07fc0000;
   localparam logic [31:0] VECTOR_REDIRECT_TOP = 32'h000000ff;
   localparam int CLK_HZ = 10000000;
   localparam int PSM_TIMEOUT_MS = 2;
   localparam int PSM_TIMEOUT_CYCLES = PSM_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int PSM_CNT_W = 24;

   typedef enum logic [1:0] {
      TCPS_PSM_IDLE = 2'h0,
      TCPS_PSM_WAIT = 2'h1,
      TCPS_PSM_DONE = 2'h3
   } tcps_psm_t;

endpackage : tcps_pkg

//--- tcps_timer_clk.sv
// One timer clock path: source select, divider and gate as a tick stream
`timescale 1ns/10ps
module tcps_timer_clk
   import tcps_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ref_tick,
   input wire logic gate_en,
   input wire logic source_sel,
   input wire logic [1:0] divider,
   output logic timer_tick
);

   logic [2:0] cnt_q;
   logic [2:0] limit;
   logic src_tick;

   // Undivided system clock ticks every cycle
   assign src_tick = source_sel ? 1'b1 : ref_tick;

   always_comb begin
      case (divider)
         2'h0: limit = 3'h0;
         2'h1: limit = 3'h1;
         2'h2: limit = 3'h3;
         default: limit = 3'h7;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !gate_en) begin
         cnt_q <= 3'h0;
         timer_tick <= 1'b0;
      end else if (src_tick) begin
         if (cnt_q >= limit) begin
            cnt_q <= 3'h0;
            timer_tick <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 3'h1;
            timer_tick <= 1'b0;
         end
      end else begin
         timer_tick <= 1'b0;
      end
   end

endmodule : tcps_timer_clk
